// [src/sirq_host.sv]
// Host controller end of the serial interrupt line
`timescale 1ns/1ns
`include "sirq_defines.svh"
module sirq_host (
    input wire logic clk_sys,
    input wire logic rst,
    sirq_if.host link,
    input wire logic cycle_req,
    input wire logic quiet_sel,
    input wire logic [3:0] start_width,
    output logic [`SIRQ_ASSIGNED-1:0] irq_state,
    output logic cycle_done,
    output logic quiet_mode,
    output logic busy
);
    logic line;
    sirq_pkg::sirq_hst_e st_q;
    sirq_pkg::sirq_hst_e st_d;
    sirq_pkg::sirq_mode_e mode_q;
    sirq_pkg::sirq_mode_e mode_d;
    logic [`SIRQ_RUN_W-1:0] cnt_q;
    logic [`SIRQ_RUN_W-1:0] cnt_d;
    logic [`SIRQ_RUN_W-1:0] stop_len_q;
    logic [`SIRQ_RUN_W-1:0] stop_len_d;
    logic [`SIRQ_RUN_W-1:0] width;
    logic first_q;
    logic first_d;
    logic [`SIRQ_ASSIGNED-1:0] irq_q;
    logic [`SIRQ_ASSIGNED-1:0] irq_d;
    logic done_q;
    logic done_d;
    logic busy_q;
    logic busy_d;
    logic oe_q;
    logic oe_d;
    logic o_q;
    logic o_d;
    logic restart;
    logic advance;
    sirq_pkg::sirq_phase_e ph_q;
    logic [`SIRQ_FRAME_W-1:0] fr_q;
    logic [`SIRQ_SLOT_W-1:0] slot_idx;

    assign line = link.serial_interrupt_line;

    // Out-of-range widths are clamped rather than rejected
    assign width = (start_width < `SIRQ_START_MIN) ? `SIRQ_START_MIN :
                   (start_width > `SIRQ_START_MAX) ? `SIRQ_START_MAX : start_width;
    assign slot_idx = `SIRQ_SLOT_W'(fr_q - `SIRQ_FIRST_SLOT);

    sirq_frame_ctr u_frame_ctr (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(restart),
        .advance(advance),
        .phase_nx(),
        .frame_nx(),
        .phase_q(ph_q),
        .frame_q(fr_q)
    );

    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        cnt_d = cnt_q;
        stop_len_d = stop_len_q;
        first_d = first_q;
        irq_d = irq_q;
        done_d = 1'b0;
        restart = 1'b0;
        case (st_q)
            sirq_pkg::SIRQ_H_IDLE: begin
                if (first_q || cycle_req) begin
                    first_d = 1'b0;
                    st_d = sirq_pkg::SIRQ_H_START;
                    cnt_d = `SIRQ_HSTART_CNT;
                end else if ((mode_q == sirq_pkg::SIRQ_MODE_QUIET) && !line && !oe_q) begin
                    // The peripheral's clock counts toward the total low time
                    st_d = sirq_pkg::SIRQ_H_START;
                    cnt_d = `SIRQ_QSTART_CNT;
                end
            end
            sirq_pkg::SIRQ_H_START: begin
                if (cnt_q >= width) begin
                    st_d = sirq_pkg::SIRQ_H_START_HI;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            sirq_pkg::SIRQ_H_START_HI: begin
                restart = 1'b1;
                st_d = sirq_pkg::SIRQ_H_FRAMES;
            end
            sirq_pkg::SIRQ_H_FRAMES: begin
                if ((ph_q == sirq_pkg::SIRQ_PH_SAMPLE) && (fr_q >= `SIRQ_FIRST_SLOT)
                    && (fr_q <= `SIRQ_LAST_ASSIGNED)) begin
                    irq_d[slot_idx] = !line;
                end
                if ((ph_q == sirq_pkg::SIRQ_PH_TURN) && (fr_q == `SIRQ_HOST_FRAMES)) begin
                    st_d = sirq_pkg::SIRQ_H_STOP;
                    cnt_d = `SIRQ_HSTART_CNT;
                    // Software leaves quiet_sel low before suspend or hot swap
                    if (quiet_sel) begin
                        stop_len_d = `SIRQ_STOP_QUIET;
                        mode_d = sirq_pkg::SIRQ_MODE_QUIET;
                    end else begin
                        stop_len_d = `SIRQ_STOP_CONT;
                        mode_d = sirq_pkg::SIRQ_MODE_CONT;
                    end
                end
            end
            sirq_pkg::SIRQ_H_STOP: begin
                if (cnt_q >= stop_len_q) begin
                    st_d = sirq_pkg::SIRQ_H_STOP_HI;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            sirq_pkg::SIRQ_H_STOP_HI: begin
                st_d = sirq_pkg::SIRQ_H_IDLE;
                done_d = 1'b1;
            end
            default: st_d = sirq_pkg::SIRQ_H_IDLE;
        endcase
        busy_d = (st_d != sirq_pkg::SIRQ_H_IDLE);
        oe_d = 1'b0;
        o_d = 1'b1;
        case (st_d)
            sirq_pkg::SIRQ_H_START, sirq_pkg::SIRQ_H_STOP: begin
                oe_d = 1'b1;
                o_d = 1'b0;
            end
            sirq_pkg::SIRQ_H_START_HI, sirq_pkg::SIRQ_H_STOP_HI: oe_d = 1'b1;
            default: oe_d = 1'b0;
        endcase
    end

    assign advance = (st_q == sirq_pkg::SIRQ_H_FRAMES);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= sirq_pkg::SIRQ_H_IDLE;
            mode_q <= sirq_pkg::SIRQ_MODE_CONT;
            cnt_q <= '0;
            stop_len_q <= `SIRQ_STOP_CONT;
            first_q <= 1'b1;
            irq_q <= '0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            oe_q <= 1'b0;
            o_q <= 1'b1;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            stop_len_q <= stop_len_d;
            first_q <= first_d;
            irq_q <= irq_d;
            done_q <= done_d;
            busy_q <= busy_d;
            oe_q <= oe_d;
            o_q <= o_d;
        end
    end

    assign link.host_oe = oe_q;
    assign link.host_o = o_q;
    assign irq_state = irq_q;
    assign cycle_done = done_q;
    assign quiet_mode = (mode_q == sirq_pkg::SIRQ_MODE_QUIET);
    assign busy = busy_q;
endmodule // sirq_host

// [include/sirq_defines.svh]
// Shared constants of the serial interrupt line ends
`ifndef SIRQ_DEFINES_SVH
`define SIRQ_DEFINES_SVH

// Number of assigned request slots, slot 1 is bit 0
`define SIRQ_ASSIGNED 21
`define SIRQ_LAST_ASSIGNED 6'h15
`define SIRQ_HOST_FRAMES 6'h15

// Frame counter and slot index widths
`define SIRQ_FRAME_W 6
`define SIRQ_FRAME_SAT 6'h3f
`define SIRQ_FIRST_SLOT 6'h01
`define SIRQ_SLOT_W 5

// Low-run measurement, in clocks
`define SIRQ_RUN_W 4
`define SIRQ_START_MIN 4'h4
`define SIRQ_START_MAX 4'h8
`define SIRQ_STOP_QUIET 4'h2
`define SIRQ_STOP_CONT 4'h3
`define SIRQ_QSTART_CNT 4'h2
`define SIRQ_HSTART_CNT 4'h1

`endif

// [include/sirq_pkg.sv]
// Types of the serial interrupt line ends; phase and mode types used by both
package sirq_pkg;

    typedef enum logic [1:0] {SIRQ_PH_SAMPLE, SIRQ_PH_RECOVER, SIRQ_PH_TURN} sirq_phase_e;

    typedef enum logic {SIRQ_MODE_CONT, SIRQ_MODE_QUIET} sirq_mode_e;

    typedef enum logic {SIRQ_P_IDLE, SIRQ_P_FRAMES} sirq_pst_e;

    typedef enum logic [2:0] {
        SIRQ_H_IDLE,
        SIRQ_H_START,
        SIRQ_H_START_HI,
        SIRQ_H_FRAMES,
        SIRQ_H_STOP,
        SIRQ_H_STOP_HI
    } sirq_hst_e;

endpackage

// [include/sirq_if.sv]
// Shared open-drain serial interrupt line joining host and peripheral
`timescale 1ns/1ns
interface sirq_if (
    input wire logic clk_sys,
    input wire logic rst
);
    logic periph_o;
    logic periph_oe;
    logic host_o;
    logic host_oe;
    logic serial_interrupt_line;

    // Pulled high; any enabled low driver wins
    assign serial_interrupt_line = ~((periph_oe & ~periph_o) | (host_oe & ~host_o));

    modport periph (
        input serial_interrupt_line,
        output periph_o,
        output periph_oe
    );

    modport host (
        input serial_interrupt_line,
        output host_o,
        output host_oe
    );
endinterface

// [src/sirq_frame_ctr.sv]
// Frame and phase tracker for the interrupt/data frames
`timescale 1ns/1ns
`include "sirq_defines.svh"
module sirq_frame_ctr (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic restart,
    input wire logic advance,
    output sirq_pkg::sirq_phase_e phase_nx,
    output logic [`SIRQ_FRAME_W-1:0] frame_nx,
    output sirq_pkg::sirq_phase_e phase_q,
    output logic [`SIRQ_FRAME_W-1:0] frame_q
);
    always_comb begin
        phase_nx = phase_q;
        frame_nx = frame_q;
        if (restart) begin
            // Clock 0 acts as the turn-around before frame 1
            phase_nx = sirq_pkg::SIRQ_PH_TURN;
            frame_nx = '0;
        end else if (advance) begin
            case (phase_q)
                sirq_pkg::SIRQ_PH_TURN: begin
                    phase_nx = sirq_pkg::SIRQ_PH_SAMPLE;
                    if (frame_q != `SIRQ_FRAME_SAT) begin
                        frame_nx = frame_q + `SIRQ_FIRST_SLOT;
                    end
                end
                sirq_pkg::SIRQ_PH_SAMPLE: phase_nx = sirq_pkg::SIRQ_PH_RECOVER;
                sirq_pkg::SIRQ_PH_RECOVER: phase_nx = sirq_pkg::SIRQ_PH_TURN;
                default: phase_nx = sirq_pkg::SIRQ_PH_TURN;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_q <= sirq_pkg::SIRQ_PH_TURN;
            frame_q <= '0;
        end else begin
            phase_q <= phase_nx;
            frame_q <= frame_nx;
        end
    end
endmodule // sirq_frame_ctr

// [src/sirq_periph.sv]
// Peripheral end of the serial interrupt line
// Summary of operation
// - Count frames from start pulse rising edge
// - Each frame: sample, recovery, turn-around clocks
// - Active request: pull line low at sample
// - Inactive request: leave line floating at sample
// - Drive high in recovery after own low
// - Release line during turn-around
// - Fixed slot order; 22 to 32 unassigned
// - Frame N sampled 3N-1 clocks after start
// - Host stops only after all frames
// - Only host drives stop, 2 or 3 clocks
// - Two-clock stop selects Quiet next cycle
// - Three-clock stop selects Continuous next cycle
// - Reset: Continuous idle, no self-started cycle
// - Host launches first cycle after reset
// - Host set Continuous before configuration changes
// - Quiet: peripheral one-clock low, host extends
// - Continuous: only host starts, 4-8 clocks low
// - One clock, shared open-drain line
`timescale 1ns/1ns
`include "sirq_defines.svh"
module sirq_periph (
    input wire logic clk_sys,
    input wire logic rst,
    sirq_if.periph link,
    input wire logic [`SIRQ_ASSIGNED-1:0] irq_req,
    output logic quiet_mode,
    output logic in_cycle
);
    logic line;
    logic [`SIRQ_RUN_W-1:0] run_q;
    logic [`SIRQ_RUN_W-1:0] run_d;
    logic rise;
    logic start_seen;
    logic stop_seen;

    sirq_pkg::sirq_pst_e st_q;
    sirq_pkg::sirq_pst_e st_d;
    sirq_pkg::sirq_mode_e mode_q;
    sirq_pkg::sirq_mode_e mode_d;
    logic in_cycle_q;
    logic in_cycle_d;
    logic restart;
    logic advance;
    logic kick;

    logic [`SIRQ_ASSIGNED-1:0] sent_q;
    logic [`SIRQ_ASSIGNED-1:0] sent_d;
    logic drv_q;
    logic drv_d;
    logic lvl_q;
    logic lvl_d;

    sirq_pkg::sirq_phase_e ph_nx;
    sirq_pkg::sirq_phase_e ph_q;
    logic [`SIRQ_FRAME_W-1:0] fr_nx;
    logic [`SIRQ_FRAME_W-1:0] fr_q;
    logic slot_valid;
    logic [`SIRQ_SLOT_W-1:0] slot_idx;

    // The partner's outputs are flops on this same clock, so no synchroniser
    assign line = link.serial_interrupt_line;

    // Low-run meter: length of the low pulse that ends on a rising edge
    always_comb begin
        if (line) begin
            run_d = '0;
        end else if (run_q == '1) begin
            run_d = run_q;
        end else begin
            run_d = run_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_q <= '0;
        end else begin
            run_q <= run_d;
        end
    end

    assign rise = line && (run_q != '0);
    // Longer than a stop pulse; upper bound not checked so a slow host still syncs
    assign start_seen = rise && (run_q >= `SIRQ_START_MIN);
    assign stop_seen = rise && ((run_q == `SIRQ_STOP_QUIET) || (run_q == `SIRQ_STOP_CONT));

    sirq_frame_ctr u_frame_ctr (
        .clk_sys(clk_sys),
        .rst(rst),
        .restart(restart),
        .advance(advance),
        .phase_nx(ph_nx),
        .frame_nx(fr_nx),
        .phase_q(ph_q),
        .frame_q(fr_q)
    );

    // Cycle state and mode
    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        restart = 1'b0;
        kick = 1'b0;
        case (st_q)
            sirq_pkg::SIRQ_P_IDLE: begin
                if (start_seen) begin
                    restart = 1'b1;
                    st_d = sirq_pkg::SIRQ_P_FRAMES;
                end else if ((mode_q == sirq_pkg::SIRQ_MODE_QUIET) && line && !drv_q
                             && (irq_req != sent_q)) begin
                    // Host takes over the low time after this one clock
                    kick = 1'b1;
                end
            end
            sirq_pkg::SIRQ_P_FRAMES: begin
                if (start_seen) begin
                    // A fresh start pulse resynchronises a lost cycle
                    restart = 1'b1;
                end else if (stop_seen) begin
                    st_d = sirq_pkg::SIRQ_P_IDLE;
                    if (run_q == `SIRQ_STOP_QUIET) begin
                        mode_d = sirq_pkg::SIRQ_MODE_QUIET;
                    end else begin
                        mode_d = sirq_pkg::SIRQ_MODE_CONT;
                    end
                end
            end
            default: st_d = sirq_pkg::SIRQ_P_IDLE;
        endcase
        in_cycle_d = (st_d == sirq_pkg::SIRQ_P_FRAMES);
    end

    assign advance = (st_q == sirq_pkg::SIRQ_P_FRAMES);

    // Slots beyond the assigned ones are never driven
    assign slot_valid = (fr_nx >= `SIRQ_FIRST_SLOT) && (fr_nx <= `SIRQ_LAST_ASSIGNED);
    // Bit 2 is SMI, bit 16 channel check, bits 17 to 20 the PCI lines
    assign slot_idx = `SIRQ_SLOT_W'(fr_nx - `SIRQ_FIRST_SLOT);

    // Line drive, registered so the pin comes from a flop
    always_comb begin
        drv_d = 1'b0;
        lvl_d = 1'b1;
        sent_d = sent_q;
        if (kick) begin
            drv_d = 1'b1;
            lvl_d = 1'b0;
        end else if (st_d == sirq_pkg::SIRQ_P_FRAMES) begin
            if ((ph_nx == sirq_pkg::SIRQ_PH_SAMPLE) && slot_valid) begin
                // Remember what was reported so Quiet mode can spot a change
                sent_d[slot_idx] = irq_req[slot_idx];
                if (irq_req[slot_idx]) begin
                    drv_d = 1'b1;
                    lvl_d = 1'b0;
                end
            end else if ((ph_nx == sirq_pkg::SIRQ_PH_RECOVER) && drv_q && !lvl_q) begin
                // Active high for one clock speeds the pull-up recovery
                drv_d = 1'b1;
                lvl_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= sirq_pkg::SIRQ_P_IDLE;
            mode_q <= sirq_pkg::SIRQ_MODE_CONT;
            in_cycle_q <= 1'b0;
            sent_q <= '0;
            drv_q <= 1'b0;
            lvl_q <= 1'b1;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            in_cycle_q <= in_cycle_d;
            sent_q <= sent_d;
            drv_q <= drv_d;
            lvl_q <= lvl_d;
        end
    end

    assign link.periph_oe = drv_q;
    assign link.periph_o = lvl_q;
    assign quiet_mode = (mode_q == sirq_pkg::SIRQ_MODE_QUIET);
    assign in_cycle = in_cycle_q;
endmodule // sirq_periph

// [dv/sirq_props.sv]
// Checker of the shared serial interrupt line
`timescale 1ns/1ns
module sirq_props (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic periph_o,
    input wire logic periph_oe,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic serial_interrupt_line
);
    logic p_low;
    logic h_low;
    logic [3:0] lrun_q, lrun_d, hrun_q, hrun_d;
    logic [6:0] pos_q, pos_d;
    logic act_q, act_d;
    assign p_low = periph_oe & ~periph_o;
    assign h_low = host_oe & ~host_o;
    // Frame position rebuilt from the wire alone, so a shifted slot is caught
    always_comb begin
        lrun_d = serial_interrupt_line ? 4'h0 : lrun_q + {3'h0, lrun_q != 4'hf};
        hrun_d = h_low ? hrun_q + {3'h0, hrun_q != 4'hf} : 4'h0;
        pos_d = pos_q + 7'h01;
        act_d = act_q && pos_q != 7'h40;
        if (serial_interrupt_line && lrun_q >= 4'h4) begin
            pos_d = 7'h01;
            act_d = 1'b1;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lrun_q <= 4'h0;
            hrun_q <= 4'h0;
            pos_q <= 7'h00;
            act_q <= 1'b0;
        end else begin
            lrun_q <= lrun_d;
            hrun_q <= hrun_d;
            pos_q <= pos_d;
            act_q <= act_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_recovery_high: assert property (p_low && act_q |=> periph_oe && periph_o)
        else $error("no recovery drive");
    a_quiet_release: assert property (p_low && !act_q |=> !periph_oe)
        else $error("start pulse too long");
    a_turn_release: assert property (periph_oe && periph_o |=> !periph_oe)
        else $error("line held in turn-around");
    a_slot_phase: assert property (p_low && act_q |-> pos_q % 7'h03 == 7'h02)
        else $error("low outside sample phase");
    a_slot_range: assert property (p_low && act_q |-> pos_q <= 7'h3e)
        else $error("unassigned slot driven");
    a_stop_late: assert property (h_low |-> !act_q)
        else $error("host low inside frames");
    a_host_run_len: assert property ($fell(h_low) |-> hrun_q >= 4'h2 && hrun_q <= 4'h8)
        else $error("host low run width");
    a_host_high_one: assert property ($fell(h_low) |-> host_oe && host_o ##1 !host_oe)
        else $error("host high clock missing");
    a_reset_idle: assert property ($fell(rst) |-> !periph_oe && !host_oe)
        else $error("driving after reset");
    c_slot_low: cover property (p_low && act_q);
    c_quiet_start: cover property (p_low && !act_q);
    c_stop_two: cover property ($fell(h_low) && hrun_q == 4'h2);
    c_stop_three: cover property ($fell(h_low) && hrun_q == 4'h3);
endmodule // sirq_props

// [dv/tb.sv]
// Testbench joining host and peripheral ends over one line
`timescale 1ns/1ns
`include "sirq_defines.svh"
module tb;
    logic clk_sys;
    logic rst;
    logic [`SIRQ_ASSIGNED-1:0] irq_req;
    logic [`SIRQ_ASSIGNED-1:0] irq_state;
    logic [`SIRQ_ASSIGNED-1:0] pats [4];
    logic cycle_req;
    logic quiet_sel;
    logic [3:0] start_width;
    logic p_quiet;
    logic in_cycle;
    logic cycle_done;
    logic h_quiet;
    logic busy;
    int bad_count = 0;
    int checks_done = 0;
    sirq_if sif (.clk_sys(clk_sys), .rst(rst));
    sirq_periph sirq_periph_inst (.clk_sys(clk_sys), .rst(rst), .link(sif.periph),
        .irq_req(irq_req), .quiet_mode(p_quiet), .in_cycle(in_cycle));
    sirq_host sirq_host_inst (.clk_sys(clk_sys), .rst(rst), .link(sif.host),
        .cycle_req(cycle_req), .quiet_sel(quiet_sel), .start_width(start_width),
        .irq_state(irq_state), .cycle_done(cycle_done), .quiet_mode(h_quiet), .busy(busy));
    sirq_props sirq_props_inst (.clk_sys(clk_sys), .rst(rst), .periph_o(sif.periph_o),
        .periph_oe(sif.periph_oe), .host_o(sif.host_o), .host_oe(sif.host_oe),
        .serial_interrupt_line(sif.serial_interrupt_line));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic bchk(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    // One whole cycle; qs means the peripheral must open it
    task automatic run_cycle(input logic [`SIRQ_ASSIGNED-1:0] p, input logic q,
        input logic [3:0] w, input logic go, input logic qs);
        int run;
        int t;
        irq_req = p;
        quiet_sel = q;
        start_width = w;
        cycle_req = go;
        run = 0;
        for (t = 0; t < 400; t++) begin
            @(negedge clk_sys);
            if (busy === 1'b1) cycle_req = 1'b0;
            if (sif.serial_interrupt_line === 1'b1 && run >= 4) break;
            if (sif.serial_interrupt_line === 1'b0) begin
                if (run == 0) bchk(sif.periph_oe & ~sif.periph_o, qs);
                if (run == 1 && qs) bchk(sif.periph_oe, 1'b0);
                run++;
            end else run = 0;
        end
        check(run, {28'h0, w});
        repeat (2) @(negedge clk_sys);
        bchk(in_cycle, 1'b1);
        for (int n = 0; n < `SIRQ_ASSIGNED; n++) begin
            bchk(sif.serial_interrupt_line, ~p[n]);
            @(negedge clk_sys);
            bchk(sif.serial_interrupt_line, 1'b1);
            repeat (2) @(negedge clk_sys);
        end
        bchk(sif.serial_interrupt_line, 1'b0);
        @(negedge clk_sys);
        bchk(sif.serial_interrupt_line, 1'b0);
        @(negedge clk_sys);
        bchk(sif.serial_interrupt_line, q);
        for (t = 0; t < 20 && cycle_done !== 1'b1; t++) @(negedge clk_sys);
        bchk(cycle_done, 1'b1);
        check({11'h0, irq_state}, {11'h0, p});
        bchk(p_quiet, q);
        bchk(h_quiet, q);
        bchk(in_cycle, 1'b0);
    endtask

    // Requests set here, changed in Continuous or already reported in Quiet, must not open a cycle
    task automatic stay_idle(input logic [`SIRQ_ASSIGNED-1:0] p);
        irq_req = p;
        repeat (40) @(negedge clk_sys);
        bchk(busy, 1'b0);
        bchk(in_cycle, 1'b0);
        bchk(sif.serial_interrupt_line, 1'b1);
    endtask

    task automatic mid_reset;
        cycle_req = 1'b1;
        repeat (30) @(negedge clk_sys);
        cycle_req = 1'b0;
        rst = 1'b1;
        @(negedge clk_sys);
        bchk(sif.serial_interrupt_line, 1'b1);
        bchk(p_quiet, 1'b0);
        bchk(in_cycle, 1'b0);
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        irq_req = 21'h000002;
        cycle_req = 1'b0;
        quiet_sel = 1'b0;
        start_width = 4'h4;
        pats = '{21'h1fffff, 21'h000000, 21'h155555, 21'h0aaaaa};
        repeat (12) @(negedge clk_sys);
        bchk(p_quiet, 1'b0);
        bchk(busy, 1'b0);
        rst = 1'b0;
        run_cycle(21'h000002, 1'b0, 4'h4, 1'b0, 1'b0);
        for (int w = 5; w <= 8; w++) run_cycle(pats[w-5], 1'b0, 4'(w), 1'b1, 1'b0);
        // Continuous idle is where configuration may change safely
        stay_idle(21'h0f0f0f);
        run_cycle(21'h0f0f0f, 1'b1, 4'h6, 1'b1, 1'b0);
        stay_idle(21'h0f0f0f);
        run_cycle(21'h100003, 1'b1, 4'h5, 1'b0, 1'b1);
        mid_reset();
        run_cycle(21'h000004, 1'b0, 4'h5, 1'b0, 1'b0);
        close_out();
    end

    // Whole run needs about 730 clocks
    initial begin
        repeat (8000) @(posedge clk_sys);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
endmodule // tb
